// ### mcbd_pkg.sv
package mcbd_pkg;

   // widths of the instruction word and the code address
   localparam int INSTR_W    = 16;
   localparam int PC_W       = 10;
   localparam int COND_W     = 6;
   localparam int START_N    = 6;

   // reset value of the program counter
   localparam logic [9:0] PC_RESET = 10'h000;

   // field positions of the instruction word
   localparam int DEST_LSB      = 0;
   localparam int DEST_W        = 5;
   localparam int COND_LSB      = 5;
   localparam int JOIDF_UC_POS  = 4;
   localparam int JOIDF_JR_POS  = 3;
   localparam int JOIDR_UC_POS  = 5;
   localparam int JOSLF_SEL_LSB = 5;
   localparam int JOSLF_JR_POS  = 4;

   // opcode patterns, compared under a mask
   localparam logic [15:0] JOCR_MASK  = 16'hf800;
   localparam logic [15:0] JOCR_CODE  = 16'h0000;
   localparam logic [15:0] JOIDF_MASK = 16'hffe7;
   localparam logic [15:0] JOIDF_CODE = 16'h3985;
   localparam logic [15:0] JOIDR_MASK = 16'hffc0;
   localparam logic [15:0] JOIDR_CODE = 16'h2f40;
   localparam logic [15:0] JOSLF_MASK = 16'hf80f;
   localparam logic [15:0] JOSLF_CODE = 16'h3801;

   // condition selector codes of the relative conditional jump
   localparam logic [5:0] C_FLAG_HI_BASE = 6'h00; // flags 8..15 high, codes 00..07
   localparam logic [5:0] C_TC_BASE      = 6'h08; // terminal counts 1..4
   localparam logic [5:0] C_START_LO     = 6'h0c;
   localparam logic [5:0] C_START_HI     = 6'h0d;
   localparam logic [5:0] C_VDS_LO_BASE  = 6'h0e; // shortcut vds 1..3 low
   localparam logic [5:0] C_SRC_LO_BASE  = 6'h11; // shortcut source 1..3 low
   localparam logic [5:0] C_VDS_HI_BASE  = 6'h14; // shortcut vds 1..3 high
   localparam logic [5:0] C_ALU_DONE     = 6'h17;
   localparam logic [5:0] C_BOOST_HI     = 6'h18;
   localparam logic [5:0] C_BOOST_LO     = 6'h19;
   localparam logic [5:0] C_CUR_HI_BASE  = 6'h1a; // cur1..3, 56l, 56h, 56n high
   localparam logic [5:0] C_CUR_LO_BASE  = 6'h20; // same six, low
   localparam logic [5:0] C_OWN_HI       = 6'h26;
   localparam logic [5:0] C_OWN_LO       = 6'h27;

   typedef enum logic [2:0] {
      MCBD_OP_NONE,
      MCBD_OP_JOCR,
      MCBD_OP_JOIDF,
      MCBD_OP_JOIDR,
      MCBD_OP_JOSLF
   } mcbd_op_type;

endpackage

// ### mcbd_cond_mux.sv
`timescale 1ns/1ps

// selects one branch condition from the feedback and flag sources
module mcbd_cond_mux (
   input  wire logic [5:0] cond_sel,       // condition selector code
   input  wire logic [7:0] flag_hi,        // flags 8..15
   input  wire logic [3:0] terminal_count_condition, // tc 1..4
   input  wire logic       start_in,       // own start input
   input  wire logic [2:0] shortcut_vds_condition,   // vds shortcut feedbacks
   input  wire logic [2:0] shortcut_source,          // source shortcut feedbacks
   input  wire logic       alu_done,       // alu request executed
   input  wire logic       boost_high_condition,     // boost voltage high
   input  wire logic [5:0] cur_fb,         // cur1..3, 56l, 56h, 56n
   input  wire logic       own_cur_fb,     // own current feedback
   output logic            cond_true       // selected condition holds
);

   // flat vector of every condition, indexed by selector code
   wire logic [39:0] cond_vec;
   assign cond_vec = {~own_cur_fb, own_cur_fb, ~cur_fb, cur_fb,
                      ~boost_high_condition, boost_high_condition, alu_done,
                      shortcut_vds_condition, ~shortcut_source,
                      ~shortcut_vds_condition, start_in, ~start_in,
                      terminal_count_condition, flag_hi};

   // unused codes read false so stray encodings never branch
   assign cond_true = (cond_sel < 6'h28) ? cond_vec[cond_sel] : 1'b0;

endmodule

// ### mcbd_pc_calc.sv
`timescale 1ns/1ps

// relative destination: pc plus sign-extended 5-bit offset
module mcbd_pc_calc (
   input  wire logic [9:0] pc_now,     // address of executing instruction
   input  wire logic [4:0] offset,     // two's complement offset
   output logic      [9:0] pc_rel      // relative destination
);

   // wraps within the 10-bit code space
   assign pc_rel = pc_now + {{5{offset[4]}}, offset};

endmodule

// ### mcbd_top.sv
`timescale 1ns/1ps

// Behaviour
// - relative conditional jump: bits 15..11 zero, condition field, 5-bit dest low.
// - condition true moves pc to relative destination, else next instruction.
// - conditions: flags 8-15, terminal counts, start, boost, own current, hi/lo.
// - one condition is true once the requested alu operation has finished.
// - shortcut vds and source low tests, and vds high tests.
// - current channels 1-3 and 5/6 l,h,n each tested high and low.
// - absolute identifier jump loads pc from selected jump register if condition holds.
// - jump register value used as absolute address, no offset.
// - identifier condition true only when selected core is the executing one.
// - absolute identifier jump encoding: fixed bits, core bit 4, register bit 3.
// - relative identifier jump branches relative when identifier matches.
// - relative destination is pc plus signed 5-bit offset, -16 to 15.
// - relative identifier jump encoding: fixed bits 15..6, core bit 5, offset low.
// - start-latch jump loads pc from jump register when selection satisfied.
// - selector names every combination of six latched starts.
// - start-latch jump encoding: 00111, selector, register bit 4, low 0001.
module mcbd_top (
   input  wire logic        clk,              // core clock, 250 MHz
   input  wire logic        rst_b,            // async reset, active low
   input  wire logic        instr_valid,      // instruction present this cycle
   input  wire logic [15:0] instr,            // instruction word
   input  wire logic        core_id,          // executing core: 0 or 1
   input  wire logic [9:0]  jump_reg_1,       // first jump register
   input  wire logic [9:0]  jump_reg_2,       // second jump register
   input  wire logic [7:0]  flag_hi,          // flags 8..15
   input  wire logic [3:0]  terminal_count_condition, // terminal counts
   input  wire logic        start_pin,        // own start input, async
   input  wire logic [5:0]  start_latched,    // latched start states
   input  wire logic [2:0]  shortcut_vds_pin, // vds shortcut feedback, async
   input  wire logic [2:0]  shortcut_src_pin, // source shortcut feedback, async
   input  wire logic        alu_done,         // alu request executed
   input  wire logic        boost_pin,        // boost voltage high, async
   input  wire logic [5:0]  cur_fb_pin,       // current feedbacks, async
   input  wire logic        own_cur_pin,      // own current feedback, async
   output logic      [9:0]  program_counter,  // current code address
   output logic             branch_taken,     // last instruction branched
   output logic             decode_hit        // instruction belongs to this group
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage read only by the second

   localparam int PIN_N = 15;
   wire  logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0]       sync1_reg;
   logic [PIN_N-1:0]       sync2_reg;

   assign pin_raw = {own_cur_pin, cur_fb_pin, boost_pin, shortcut_src_pin,
                     shortcut_vds_pin, start_pin};

   // two flops per pin; feedback lines are asynchronous to clk
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   wire logic       start_s;
   wire logic [2:0] vds_s;
   wire logic [2:0] src_s;
   wire logic       boost_s;
   wire logic [5:0] cur_s;
   wire logic       own_s;
   assign start_s = sync2_reg[0];
   assign vds_s   = sync2_reg[3:1];
   assign src_s   = sync2_reg[6:4];
   assign boost_s = sync2_reg[7];
   assign cur_s   = sync2_reg[13:8];
   assign own_s   = sync2_reg[14];

   ////////////////////////////////////////////////////////////////////////
   // opcode decode

   function automatic logic match(input logic [15:0] word,
                                  input logic [15:0] mask,
                                  input logic [15:0] code);
      match = ((word & mask) == code);
   endfunction

   wire logic hit_jocr;
   wire logic hit_joidf;
   wire logic hit_joidr;
   wire logic hit_joslf;
   assign hit_jocr  = match(instr, mcbd_pkg::JOCR_MASK, mcbd_pkg::JOCR_CODE);
   assign hit_joidf = match(instr, mcbd_pkg::JOIDF_MASK, mcbd_pkg::JOIDF_CODE);
   assign hit_joidr = match(instr, mcbd_pkg::JOIDR_MASK, mcbd_pkg::JOIDR_CODE);
   assign hit_joslf = match(instr, mcbd_pkg::JOSLF_MASK, mcbd_pkg::JOSLF_CODE);

   // patterns are disjoint, so order only matters for readability
   mcbd_pkg::mcbd_op_type op;
   always_comb begin
      if (!instr_valid)
         op = mcbd_pkg::MCBD_OP_NONE;
      else if (hit_jocr)
         op = mcbd_pkg::MCBD_OP_JOCR;
      else if (hit_joidf)
         op = mcbd_pkg::MCBD_OP_JOIDF;
      else if (hit_joidr)
         op = mcbd_pkg::MCBD_OP_JOIDR;
      else if (hit_joslf)
         op = mcbd_pkg::MCBD_OP_JOSLF;
      else
         op = mcbd_pkg::MCBD_OP_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // fields and conditions

   wire logic [5:0] cond_sel;
   wire logic [4:0] dest;
   wire logic [5:0] start_sel;
   wire logic       cond_true;
   wire logic [9:0] pc_rel;
   wire logic [9:0] pc_seq;
   assign cond_sel  = instr[mcbd_pkg::COND_LSB +: mcbd_pkg::COND_W];
   assign dest      = instr[mcbd_pkg::DEST_LSB +: mcbd_pkg::DEST_W];
   assign start_sel = instr[mcbd_pkg::JOSLF_SEL_LSB +: mcbd_pkg::START_N];
   assign pc_seq    = program_counter + 10'h001;

   // condition source; all selectable tests live in the mux
   mcbd_cond_mux u_cond (
      .cond_sel                 (cond_sel),
      .flag_hi                  (flag_hi),
      .terminal_count_condition (terminal_count_condition),
      .start_in                 (start_s),
      .shortcut_vds_condition   (vds_s),
      .shortcut_source          (src_s),
      .alu_done                 (alu_done),
      .boost_high_condition     (boost_s),
      .cur_fb                   (cur_s),
      .own_cur_fb               (own_s),
      .cond_true                (cond_true)
   );

   mcbd_pc_calc u_rel (
      .pc_now (program_counter),
      .offset (dest),
      .pc_rel (pc_rel)
   );

   // identifier match against the executing core
   wire logic core_id_select;
   wire logic core_id_match;
   wire logic jump_register_select;
   wire logic [9:0] jr_abs;
   assign core_id_select = (op == mcbd_pkg::MCBD_OP_JOIDR) ?
                           instr[mcbd_pkg::JOIDR_UC_POS] : instr[mcbd_pkg::JOIDF_UC_POS];
   assign core_id_match  = (core_id_select == core_id);
   assign jump_register_select = (op == mcbd_pkg::MCBD_OP_JOSLF) ?
                           instr[mcbd_pkg::JOSLF_JR_POS] : instr[mcbd_pkg::JOIDF_JR_POS];
   // absolute value, no offset added
   assign jr_abs = jump_register_select ? jump_reg_2 : jump_reg_1;

   // start mask needs an exact match, so "none" means no start latched
   wire logic start_match;
   assign start_match = (start_latched == start_sel);

   ////////////////////////////////////////////////////////////////////////
   // next program counter

   logic       take;
   logic [9:0] pc_next;
   always_comb begin
      take    = 1'b0;
      pc_next = pc_seq;
      unique case (op)
         mcbd_pkg::MCBD_OP_NONE: begin
            take = 1'b0;
         end
         mcbd_pkg::MCBD_OP_JOCR: begin
            take = cond_true;
            if (take) pc_next = pc_rel;
         end
         mcbd_pkg::MCBD_OP_JOIDF: begin
            take = core_id_match;
            if (take) pc_next = jr_abs;
         end
         mcbd_pkg::MCBD_OP_JOIDR: begin
            take = core_id_match;
            if (take) pc_next = pc_rel;
         end
         mcbd_pkg::MCBD_OP_JOSLF: begin
            take = start_match;
            if (take) pc_next = jr_abs;
         end
      endcase
   end

   wire logic advance;
   assign advance = instr_valid;

   // pc holds when no instruction executes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         program_counter <= mcbd_pkg::PC_RESET;
         branch_taken    <= 1'b0;
      end else begin
         if (advance) program_counter <= pc_next;
         branch_taken <= take;
      end
   end

   assign decode_hit = (op != mcbd_pkg::MCBD_OP_NONE);

endmodule

// ### mcbd_top_sva.sv
`timescale 1ns/1ps

// watches the branch group at the top ports only
module mcbd_top_chk (
   input wire logic        clk,             // core clock
   input wire logic        rst_b,           // async reset
   input wire logic        instr_valid,     // instruction taken
   input wire logic [15:0] instr,           // instruction word
   input wire logic        core_id,         // executing core
   input wire logic [9:0]  jump_reg_1,      // first jump register
   input wire logic [9:0]  jump_reg_2,      // second jump register
   input wire logic [7:0]  flag_hi,         // flags 8..15
   input wire logic [5:0]  start_latched,   // latched starts
   input wire logic        alu_done,        // alu finished
   input wire logic [9:0]  program_counter, // code address
   input wire logic        branch_taken,    // last one branched
   input wire logic        decode_hit       // group member
);
   ////////////////////////////////////////////////////////////////////////////////
   // opcode matches and candidate destinations
   wire logic       jocr_w  = instr_valid &&
                              ((instr & mcbd_pkg::JOCR_MASK) == mcbd_pkg::JOCR_CODE);
   wire logic       joidf_w = instr_valid &&
                              ((instr & mcbd_pkg::JOIDF_MASK) == mcbd_pkg::JOIDF_CODE);
   wire logic       joidr_w = instr_valid &&
                              ((instr & mcbd_pkg::JOIDR_MASK) == mcbd_pkg::JOIDR_CODE);
   wire logic       joslf_w = instr_valid &&
                              ((instr & mcbd_pkg::JOSLF_MASK) == mcbd_pkg::JOSLF_CODE);
   wire logic [9:0] rel_w   = program_counter + {{5{instr[4]}}, instr[4:0]};
   wire logic [9:0] step_w  = program_counter + 10'h001;
   wire logic [9:0] jrf_w   = instr[3] ? jump_reg_2 : jump_reg_1;
   wire logic [9:0] jrs_w   = instr[4] ? jump_reg_2 : jump_reg_1;

   ////////////////////////////////////////////////////////////////////////////////
   // one clock domain, so clocking and disable are declared once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_idle_pc_hold: assert property (!instr_valid |=> program_counter == $past(program_counter)
      && !branch_taken) else $error("pc moved without an instruction");
   a_jocr_decode_hit: assert property (jocr_w |-> decode_hit)
      else $error("relative conditional jump not decoded");
   a_jocr_dest_sel: assert property (jocr_w |=> program_counter ==
      (branch_taken ? $past(rel_w) : $past(step_w)))
      else $error("relative jump destination wrong");
   a_jocr_flag_cond: assert property (jocr_w && instr[10:8] == 3'h0 |=>
      branch_taken == $past(flag_hi[instr[7:5]])) else $error("flag condition wrong");
   a_jocr_alu_cond: assert property (
      jocr_w && instr[10:5] == mcbd_pkg::C_ALU_DONE |=> branch_taken == $past(alu_done))
      else $error("alu completion condition wrong");
   a_joidf_far_jump: assert property (joidf_w |=>
      program_counter == ($past(instr[4] == core_id) ? $past(jrf_w) : $past(step_w)))
      else $error("joidf wrong");
   a_joidr_rel_jump: assert property (joidr_w |=>
      branch_taken == $past(instr[5] == core_id)
      && program_counter == (branch_taken ? $past(rel_w) : $past(step_w)))
      else $error("joidr wrong");
   a_joslf_far_jump: assert property (joslf_w |=>
      branch_taken == $past(instr[10:5] == start_latched)
      && program_counter == (branch_taken ? $past(jrs_w) : $past(step_w)))
      else $error("joslf wrong");
   a_group_decode_hit: assert property (joidf_w || joidr_w || joslf_w |-> decode_hit)
      else $error("jump group member not decoded");
   a_other_op_step: assert property (instr_valid && !decode_hit |=>
      program_counter == $past(step_w) && !branch_taken) else $error("unknown opcode not stepped");
endmodule

// ### mcbd_seq_model.sv
`timescale 1ns/1ps

// sequencer side: jump registers and the arithmetic unit's completion
module mcbd_seq_model (
   input  wire logic       clk,        // core clock
   output logic      [9:0] jump_reg_1, // first jump register
   output logic      [9:0] jump_reg_2, // second jump register
   output logic            alu_done    // alu request executed
);
   // far addresses chosen away from the sequential path so a miss shows
   initial begin
      jump_reg_1 = 10'h2a5;
      jump_reg_2 = 10'h15a;
      alu_done   = 1'b1;
   end

   // a request clears completion, which returns after lat cycles
   task automatic alu_request(input int lat);
      alu_done = 1'b0;
      repeat (lat) @(negedge clk);
      alu_done = 1'b1;
   endtask
endmodule

// ### mcbd_top_tb.sv
`timescale 1ns/1ps

module mcbd_top_tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic        core_id = 1'b0;
   logic [7:0]  flag_hi = 8'h00;
   logic [3:0]  terminal_count_condition = 4'h0;
   logic        start_pin = 1'b0;
   logic [5:0]  start_latched = 6'h00;
   logic [2:0]  shortcut_vds_pin = 3'h0;
   logic [2:0]  shortcut_src_pin = 3'h0;
   logic        boost_pin = 1'b0;
   logic [5:0]  cur_fb_pin = 6'h00;
   logic        own_cur_pin = 1'b0;
   wire logic [9:0] jump_reg_1;
   wire logic [9:0] jump_reg_2;
   wire logic       alu_done;
   wire logic [9:0] program_counter;
   wire logic       branch_taken;
   wire logic       decode_hit;
   logic [9:0]  exp_pc = 10'h000;
   int          n_errors = 0;
   int          compares = 0;

   always #2 clk = ~clk;
   mcbd_top       dut (.*);
   mcbd_seq_model seq (.*);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   // entered on a falling edge; the pc has moved by the next one
   task automatic exec(input logic [15:0] ins, input logic take, input logic [9:0] dst);
      instr_valid = 1'b1;
      instr = ins;
      @(negedge clk);
      exp_pc = take ? dst : exp_pc + 10'h001;
      chk(program_counter === exp_pc && branch_taken === take, "jump outcome");
   endtask

   // idle gap also lets the two-flop synchronisers settle
   task automatic idle(input int n, input string name);
      instr_valid = 1'b0;
      repeat (n) @(negedge clk);
      chk(program_counter === exp_pc && branch_taken === 1'b0, "pc not held");
      $display("test %s done", name);
   endtask

   function automatic logic [9:0] rel(input logic [4:0] d);
      return exp_pc + {{5{d[4]}}, d};
   endfunction

   // expected condition vector, code 0 at the lsb
   function automatic logic cond_exp(input logic [5:0] c);
      logic [39:0] v;
      v = {~own_cur_pin, own_cur_pin, ~cur_fb_pin, cur_fb_pin, ~boost_pin, boost_pin, alu_done,
           shortcut_vds_pin, ~shortcut_src_pin, ~shortcut_vds_pin, start_pin, ~start_pin,
           terminal_count_condition, flag_hi};
      return (c < 6'h28) ? v[c] : 1'b0;
   endfunction

   task automatic t_reset();
      rst_b = 1'b0;
      @(negedge clk);
      exp_pc = 10'h000;
      chk(program_counter === 10'h000 && branch_taken === 1'b0, "reset values");
      rst_b = 1'b1;
      idle(1, "reset");
   endtask

   // every selector code, sources in one pattern then its inverse
   task automatic t_cond(input logic inv);
      flag_hi = 8'ha5 ^ {8{inv}};
      terminal_count_condition = 4'h5 ^ {4{inv}};
      {start_pin, boost_pin, own_cur_pin} = {3{~inv}};
      shortcut_vds_pin = 3'h2 ^ {3{inv}};
      shortcut_src_pin = 3'h5 ^ {3{inv}};
      cur_fb_pin = 6'h2a ^ {6{inv}};
      idle(3, "cond setup");
      for (int c = 0; c < 64; c++) begin
         exec({5'h00, c[5:0], inv ? 5'h10 : 5'h0f}, cond_exp(c[5:0]),
              rel(inv ? 5'h10 : 5'h0f));
      end
      idle(1, "conditions");
   endtask

   task automatic t_alu();
      fork
         seq.alu_request(5);
      join_none
      exec(16'h02e3, 1'b0, 10'h000);
      idle(6, "alu wait");
      exec(16'h02e3, 1'b1, rel(5'h03));
      idle(1, "alu");
   endtask

   task automatic t_ident();
      for (int k = 0; k < 8; k++) begin
         core_id = k[2];
         exec(16'h3985 | {11'h0, k[1], k[0], 3'h0}, k[1] == k[2],
              k[0] ? jump_reg_2 : jump_reg_1);
         exec({10'h0bd, k[1], k[0] ? 5'h10 : 5'h0f}, k[1] == k[2],
              rel(k[0] ? 5'h10 : 5'h0f));
      end
      idle(1, "identifier");
   endtask

   task automatic t_start();
      logic [5:0] pat [3] = '{6'h00, 6'h2d, 6'h3f};
      for (int p = 0; p < 3; p++) begin
         start_latched = pat[p];
         for (int m = 0; m < 64; m++) begin
            exec({5'h07, m[5:0], m[0], 4'h1}, m[5:0] == pat[p],
                 m[0] ? jump_reg_2 : jump_reg_1);
         end
      end
      idle(1, "start latch");
   endtask

   task automatic t_refuse();
      logic [15:0] w [3] = '{16'hffff, 16'h3984, 16'h3800};
      for (int i = 0; i < 3; i++) begin
         instr_valid = 1'b1;
         instr = w[i];
         #1 chk(decode_hit === 1'b0, "foreign opcode decoded");
         exec(w[i], 1'b0, 10'h000);
      end
      idle(1, "refuse");
   endtask

   task automatic end_of_test();
      $display("counts: compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge clk);
      t_reset();
      t_cond(1'b0);
      t_cond(1'b1);
      t_alu();
      t_ident();
      t_reset();
      t_start();
      t_refuse();
      end_of_test();
   end

   // the run needs about 383 cycles; this allows about thirteen times that
   initial begin
      #20000;
      n_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule

bind mcbd_top mcbd_top_chk chk (.*);
